//--- core/sdfi_drive.sv
/*
  drive end: turns step commands into a microstep position, latches
  protection faults and blinks the red fault indicator.
  assumes command inputs and fault sense inputs are synchronous to clk.
*/
// Summary of operation
// R1: controller enables 5 us before direction change; sdfi_ctrl only holds enable one cycle before accepting a move
// R2: direction settles 5 us before step edge
// R3: step high at least 2.5 us
// R4: step low at least 2.5 us
// R5: indicator repeats in 3 second periods
// R6: blink count identifies the fault
// R7: show one fault, current then voltage then phase
// R8: over-current gives one blink
// R9: over-voltage gives two blinks
// R10: phase error gives four blinks
// R11: any fault de-energizes the motor
// R12: faults stay latched until power cycle
// R13: step/direction or dual pulse command mode
// R14: active step edge is selectable
// R15: count position on active edge when enabled
// R16: blinks evenly spaced at period start
module sdfi_drive
  import sdfi_pkg::*;
#(
  parameter int PERIOD_CYC = SDFI_PERIOD_CYC,
  parameter int SLOT_CYC = SDFI_SLOT_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  sdfi_if.drive link,
  input wire logic over_current_sense,
  input wire logic over_voltage_sense,
  input wire logic phase_error_sense,
  input wire logic dual_pulse_command_mode,
  input wire logic falling_edge_active,
  output logic [SDFI_POS_W-1:0] position,
  output logic [2:0] fault_code
);
  // elaboration check: four blinks need nine slots in a period
  if (SLOT_CYC < 2 || PERIOD_CYC < 9 * SLOT_CYC) begin : g_bad_period
    $error("sdfi_drive: period too short for four blinks");
  end

  typedef struct packed {
    logic step_d;
    logic ccw_d;
    logic oc;
    logic ov;
    logic ph;
    logic [31:0] period_cnt;
    logic led;
    logic energized;
    logic [SDFI_POS_W-1:0] pos;
    logic [2:0] code;
  } sdfi_drive_state_t;

  sdfi_drive_state_t s;
  sdfi_drive_state_t next_s;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic active_edge(input logic prev, input logic cur, input logic fall);
    active_edge = fall ? (prev && !cur) : (!prev && cur);
  endfunction

  always_comb begin
    logic fault_any;
    logic cw_hit;
    logic ccw_hit;
    logic [31:0] slot;
    fault_any = 1'b0;
    cw_hit = 1'b0;
    ccw_hit = 1'b0;
    slot = 32'h0;
    next_s = s;
    next_s.step_d = link.step_pulse_in;
    next_s.ccw_d = link.ccw_pulse_in;
    // R12: sticky fault latch
    next_s.oc = s.oc | over_current_sense;
    next_s.ov = s.ov | over_voltage_sense;
    next_s.ph = s.ph | phase_error_sense;
    fault_any = next_s.oc | next_s.ov | next_s.ph;
    // R11: de-energize on fault
    next_s.energized = link.drive_enable_in && !fault_any;
    // R7: priority select
    if (next_s.oc) begin
      // R8: one blink
      next_s.code = SDFI_BLINKS_OVER_CURRENT;
    end else if (next_s.ov) begin
      // R9: two blinks
      next_s.code = SDFI_BLINKS_OVER_VOLTAGE;
    end else if (next_s.ph) begin
      // R10: four blinks
      next_s.code = SDFI_BLINKS_PHASE_ERROR;
    end else begin
      next_s.code = SDFI_BLINKS_NONE;
    end
    // R5: three second period
    if (s.code == SDFI_BLINKS_NONE || s.period_cnt == 32'(PERIOD_CYC - 1)) begin
      next_s.period_cnt = 32'h0;
    end else begin
      next_s.period_cnt = s.period_cnt + 32'h1;
    end
    // R16: even slots, on then off
    slot = s.period_cnt / 32'(SLOT_CYC);
    // R6: count on-slots
    next_s.led = (s.code != SDFI_BLINKS_NONE) && !slot[0] &&
                 (slot[31:1] < {28'h0, s.code});
    // R13: command mode select
    // R14: edge polarity
    cw_hit = active_edge(s.step_d, link.step_pulse_in, falling_edge_active);
    ccw_hit = dual_pulse_command_mode &&
              active_edge(s.ccw_d, link.ccw_pulse_in, falling_edge_active);
    // R15: advance position
    // R2: direction sampled at the edge
    if (s.energized && link.drive_enable_in && !fault_any) begin
      if (dual_pulse_command_mode) begin
        if (cw_hit && !ccw_hit) begin
          next_s.pos = s.pos + 1'b1;
        end else if (ccw_hit && !cw_hit) begin
          next_s.pos = s.pos - 1'b1;
        end
      end else if (cw_hit) begin
        next_s.pos = link.dir_in ? s.pos + 1'b1 : s.pos - 1'b1;
      end
    end
  end

  // power-on reset is the only clear for the latches
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign link.fault_led = s.led;
  assign link.motor_energized = s.energized;
  assign position = s.pos;
  assign fault_code = s.code;
endmodule

//--- inc/sdfi_pkg.sv
/*
  package for the step/direction input and fault indicator block:
  timing constants, blink codes and enum types shared by both ends.
  assumes a single 25 MHz clock on both ends.
*/
package sdfi_pkg;
  localparam int SDFI_CLK_HZ = 25_000_000;
  localparam int SDFI_CLK_NS = 40;
  // ****************************************
  // controller timing minimums
  // ****************************************
  localparam int SDFI_EN_DIR_LEAD_NS = 5000;
  localparam int SDFI_DIR_STEP_LEAD_NS = 5000;
  localparam int SDFI_STEP_HIGH_NS = 2500;
  localparam int SDFI_STEP_LOW_NS = 2500;
  // least times round up
  localparam int SDFI_EN_DIR_LEAD_CYC = (SDFI_EN_DIR_LEAD_NS + SDFI_CLK_NS - 1) / SDFI_CLK_NS;
  localparam int SDFI_DIR_STEP_LEAD_CYC =
    (SDFI_DIR_STEP_LEAD_NS + SDFI_CLK_NS - 1) / SDFI_CLK_NS;
  localparam int SDFI_STEP_HIGH_CYC = (SDFI_STEP_HIGH_NS + SDFI_CLK_NS - 1) / SDFI_CLK_NS;
  localparam int SDFI_STEP_LOW_CYC = (SDFI_STEP_LOW_NS + SDFI_CLK_NS - 1) / SDFI_CLK_NS;
  // ****************************************
  // fault indication
  // ****************************************
  localparam int SDFI_PERIOD_S = 3;
  localparam int SDFI_PERIOD_CYC = SDFI_PERIOD_S * SDFI_CLK_HZ;
  localparam int SDFI_SLOT_CYC = SDFI_CLK_HZ / 4;
  localparam logic [2:0] SDFI_BLINKS_OVER_CURRENT = 3'h1;
  localparam logic [2:0] SDFI_BLINKS_OVER_VOLTAGE = 3'h2;
  localparam logic [2:0] SDFI_BLINKS_PHASE_ERROR = 3'h4;
  localparam logic [2:0] SDFI_BLINKS_NONE = 3'h0;
  localparam int SDFI_POS_W = 32;

  typedef enum logic [1:0] {
    SDFI_ST_IDLE,
    SDFI_ST_LEAD,
    SDFI_ST_HIGH,
    SDFI_ST_LOW
  } sdfi_gen_state_t;
endpackage

//--- inc/sdfi_if.sv
/*
  interface joining the motion controller to the drive's command
  inputs and fault outputs. assumes one shared clock.
*/
interface sdfi_if;
  logic step_pulse_in;
  logic dir_in;
  logic drive_enable_in;
  logic ccw_pulse_in;
  logic fault_led;
  logic motor_energized;

  modport drive (
    input step_pulse_in,
    input dir_in,
    input drive_enable_in,
    input ccw_pulse_in,
    output fault_led,
    output motor_energized
  );
  modport ctrl (
    output step_pulse_in,
    output dir_in,
    output drive_enable_in,
    output ccw_pulse_in,
    input fault_led,
    input motor_energized
  );
endinterface

//--- core/sdfi_ctrl.sv
/*
  controller end: issues step moves honoring direction and pulse width
  minimums; enable need only lead a move by one cycle. assumes the drive shares clk.
*/
module sdfi_ctrl
  import sdfi_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  sdfi_if.ctrl link,
  input wire logic enable,
  input wire logic move_req,
  input wire logic move_dir,
  output logic busy
);
  typedef struct packed {
    sdfi_gen_state_t st;
    logic [15:0] cnt;
    logic en;
    logic dir;
    logic step;
    logic busy;
  } sdfi_ctrl_state_t;

  sdfi_ctrl_state_t s;
  sdfi_ctrl_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.en = enable;
    if (s.cnt != 16'h0) begin
      next_s.cnt = s.cnt - 16'h1;
    end
    unique case (s.st)
      SDFI_ST_IDLE: begin
        next_s.busy = 1'b0;
        // R1: enable leads direction
        if (move_req && s.en && enable) begin
          next_s.busy = 1'b1;
          next_s.dir = move_dir;
          next_s.st = SDFI_ST_LEAD;
          next_s.cnt = 16'(SDFI_DIR_STEP_LEAD_CYC);
        end
      end
      SDFI_ST_LEAD: begin
        // R2: direction lead time
        if (s.cnt == 16'h0) begin
          next_s.step = 1'b1;
          next_s.st = SDFI_ST_HIGH;
          next_s.cnt = 16'(SDFI_STEP_HIGH_CYC - 1);
        end
      end
      SDFI_ST_HIGH: begin
        // R3: step high width
        if (s.cnt == 16'h0) begin
          next_s.step = 1'b0;
          next_s.st = SDFI_ST_LOW;
          next_s.cnt = 16'(SDFI_STEP_LOW_CYC - 1);
        end
      end
      SDFI_ST_LOW: begin
        // R4: step low width
        if (s.cnt == 16'h0) begin
          next_s.st = SDFI_ST_IDLE;
          next_s.busy = 1'b0;
        end
      end
    endcase
  end

  // enable held a cycle before idle accepts a move; lead counted down to 0
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '{st: SDFI_ST_IDLE, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign link.step_pulse_in = s.step;
  assign link.dir_in = s.dir;
  assign link.drive_enable_in = s.en;
  assign link.ccw_pulse_in = 1'b0;
  assign busy = s.busy;
endmodule

//--- bench/sdfi_chk.sv
/* checker for the sdfi link: controller timing and indicator shape.
   assumes SLOT_CYC 4 and PERIOD_CYC 40 on the drive, one clock. */
module sdfi_chk (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic step_pulse_in,
  input wire logic dir_in,
  input wire logic drive_enable_in,
  input wire logic ccw_pulse_in,
  input wire logic fault_led,
  input wire logic motor_energized
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] st_c;
  logic [7:0] dr_c;
  logic [7:0] en_c;
  logic seen;
  // ****************
  // helpers
  // ****************
  // cycles since last change; saturate so long idle never wraps
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_c <= 8'h0;
      dr_c <= 8'h0;
      en_c <= 8'h0;
      seen <= 1'b0;
    end else begin
      st_c <= $changed(step_pulse_in) ? 8'h1 : st_c + {7'h0, st_c != 8'hff};
      dr_c <= $changed(dir_in) ? 8'h1 : dr_c + {7'h0, dr_c != 8'hff};
      en_c <= $changed(drive_enable_in) ? 8'h1 : en_c + {7'h0, en_c != 8'hff};
      seen <= seen | fault_led;
    end
  end
  // ****************
  // checks
  // ****************
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_blink;
    fault_led [*4] ##1 !fault_led;
  endsequence
  sequence s_gap;
    !fault_led [*4];
  endsequence
  a_en_dir_lead: assert property ($changed(dir_in) |-> en_c >= 8'd125)
    else $error("enable lead too short");
  a_dir_step_lead: assert property ($rose(step_pulse_in) |-> dr_c >= 8'd125)
    else $error("direction lead too short");
  a_step_high_min: assert property ($fell(step_pulse_in) |-> st_c >= 8'd63)
    else $error("step high too short");
  a_step_low_min: assert property ($rose(step_pulse_in) |-> st_c >= 8'd63)
    else $error("step low too short");
  a_blink_width: assert property ($rose(fault_led) |-> s_blink)
    else $error("blink width wrong");
  a_blink_gap: assert property ($fell(fault_led) |-> s_gap)
    else $error("blink gap too short");
  a_led_period: assert property ($rose(fault_led) |-> ##40 $rose(fault_led))
    else $error("blink does not repeat");
  a_fault_freewheel: assert property (seen |-> !motor_energized)
    else $error("motor on after fault");
  a_off_disabled: assert property (!drive_enable_in |=> !motor_energized)
    else $error("motor on while disabled");
endmodule

//--- bench/step_dir_input_fault_indicator_tb.sv
/* testbench: controller end drives drive end over sdfi_if.
   assumes short indicator counts (slot 4, period 40) and a 25 MHz clock. */
module step_dir_input_fault_indicator_tb;
  import sdfi_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic enable = 1'b0;
  logic move_req = 1'b0;
  logic move_dir = 1'b0;
  logic [2:0] sense = 3'h0;
  logic dual = 1'b0;
  logic fall = 1'b0;
  logic busy;
  logic [SDFI_POS_W-1:0] position;
  logic [2:0] fault_code;
  int error_cnt = 0;
  int checks_done = 0;
  // row: direction, then expected position
  logic [32:0] rows [4] = '{{1'b1, 32'h1}, {1'b1, 32'h2}, {1'b0, 32'h1}, {1'b1, 32'h2}};
  sdfi_if link ();
  sdfi_drive #(.PERIOD_CYC(40), .SLOT_CYC(4)) i_sdfi_drive (.clk(clk), .arst_n(arst_n),
    .link(link.drive), .over_current_sense(sense[2]), .over_voltage_sense(sense[1]),
    .phase_error_sense(sense[0]), .dual_pulse_command_mode(dual),
    .falling_edge_active(fall), .position(position), .fault_code(fault_code));
  sdfi_ctrl i_sdfi_ctrl (.clk(clk), .arst_n(arst_n), .link(link.ctrl), .enable(enable),
    .move_req(move_req), .move_dir(move_dir), .busy(busy));
  sdfi_chk i_sdfi_chk (.clk(clk), .arst_n(arst_n), .step_pulse_in(link.step_pulse_in),
    .dir_in(link.dir_in), .drive_enable_in(link.drive_enable_in),
    .ccw_pulse_in(link.ccw_pulse_in), .fault_led(link.fault_led),
    .motor_energized(link.motor_energized));
  // ****************
  // tasks
  // ****************
  always #20 clk = ~clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rst();
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
  endtask
  task automatic move(input logic d);
    int n;
    n = 0;
    @(posedge clk);
    move_dir <= d;
    move_req <= 1'b1;
    repeat (2) @(posedge clk);
    move_req <= 1'b0;
    do begin
      @(negedge clk);
      n++;
    end while (busy === 1'b1 && n < 400);
  endtask
  // one short sense pulse; blinks counted over one whole period
  task automatic flt(input logic [2:0] s, input logic [2:0] code);
    int n;
    logic p;
    rst();
    sense <= s;
    @(posedge clk);
    sense <= 3'h0;
    repeat (45) @(posedge clk);
    n = 0;
    @(negedge clk);
    p = link.fault_led;
    repeat (40) begin
      @(negedge clk);
      n += (link.fault_led === 1'b1 && p !== 1'b1);
      p = link.fault_led;
    end
    chk(n, code);
    chk(fault_code, code);
    chk(link.motor_energized, 1'b0);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ****************
  // sequence
  // ****************
  initial begin
    #400000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    rst();
    @(negedge clk);
    chk(position, 32'h0);
    chk({fault_code, link.fault_led}, 32'h0);
    @(posedge clk);
    enable <= 1'b1;
    // a_en_dir_lead needs enable at least 125 cycles ahead of the first direction change
    repeat (130) @(posedge clk);
    foreach (rows[i]) begin
      move(rows[i][32]);
      chk(position, rows[i][31:0]);
    end
    @(posedge clk);
    fall <= 1'b1;
    move(1'b1);
    chk(position, 32'h3);
    @(posedge clk);
    dual <= 1'b1;
    move(1'b0);
    chk(position, 32'h4);
    @(posedge clk);
    enable <= 1'b0;
    move(1'b1);
    chk(position, 32'h4);
    chk(link.motor_energized, 32'h0);
    @(posedge clk);
    enable <= 1'b1;
    repeat (130) @(posedge clk);
    flt(3'b001, SDFI_BLINKS_PHASE_ERROR);
    flt(3'b011, SDFI_BLINKS_OVER_VOLTAGE);
    flt(3'b111, SDFI_BLINKS_OVER_CURRENT);
    // enable must lead the direction change after the last reset
    repeat (130) @(posedge clk);
    move(1'b1);
    chk(position, 32'h0);
    report_and_stop();
  end
endmodule
